// ---- src/dsc_mode_ctrl.sv ----
// speed, lock-to-disc and standby control with an axi4-lite register slave
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
module dsc_mode_ctrl
  import dsc_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [2:0]        serialAudioIn,
  input  wire logic              errorFlagIn,
  input  wire logic              biphaseIn,
  input  wire logic [1:0]        motorPwmIn,
  input  wire logic [1:0]        motorPdmIn,
  input  wire logic              correctionFlagIn,
  input  wire logic [1:0]        versatilePinIn,
  input  wire logic [2:0]        versatileFromCore,
  output logic [2:0]             serialAudioOut,
  output logic [2:0]             serialAudioOeN,
  output logic                   secondLevelErrorFlag,
  output logic                   secondLevelErrorFlagOeN,
  output logic                   biphaseMarkOutput,
  output logic                   biphaseMarkOutputOeN,
  output logic                   motorDriveOutA,
  output logic                   motorDriveOutB,
  output logic                   motorDriveOeN,
  output logic                   correctionFlagOutput,
  output logic                   correctionFlagOutputOeN,
  output logic [1:0]             versatileToCore,
  output logic [2:0]             versatilePinOut,
  output logic                   fixedClockOutput,
  output logic                   hostClockOutput,
  output logic [1:0]             overspeedFactor,
  output logic                   lockToDiscActive,
  output logic                   coreActive,
  output logic                   audioFeaturesOff,
  output logic                   ioShutdown,
  output logic                   subcodeActive
);

  // elaboration guard on the address width
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 4 and 32");
  end

  logic [3:0]        speedA;
  logic [3:0]        speedB;
  logic [3:0]        clkCfg;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0]       wData;
  logic [3:0]        wStrb;
  logic [1:0]        vSync1;
  dsc_speed_t        speed;
  dsc_speed_t        next_speed;
  dsc_mode_t         mode;
  dsc_mode_t         next_mode;

  logic              wrFire;
  logic              rdTake;
  logic              wrIsA;
  logic              wrIsB;
  logic              wrIsCfg;
  logic              wrIsStat;
  logic              wrMapped;
  logic              rdIsA;
  logic              rdIsB;
  logic              rdIsCfg;
  logic              rdIsStat;
  logic              rdMapped;
  logic [31:0]       rdMux;
  logic [31:0]       statWord;
  logic              standby;
  logic              stopMode;
  logic [1:0]        stbyField;

  // write happens once address and data are both held; unaffected by standby
  assign wrFire   = !awready && !wready && !bvalid;
  assign rdTake   = arvalid && arready;
  assign wrIsA    = (awAddr == ADDR_W'(ADDR_SPD_A));
  assign wrIsB    = (awAddr == ADDR_W'(ADDR_SPD_B));
  assign wrIsCfg  = (awAddr == ADDR_W'(ADDR_CFG));
  assign wrIsStat = (awAddr == ADDR_W'(ADDR_STAT));
  assign wrMapped = wrIsA || wrIsB || wrIsCfg || wrIsStat;

  // read decode and data selection
  assign rdIsA    = (araddr == ADDR_W'(ADDR_SPD_A));
  assign rdIsB    = (araddr == ADDR_W'(ADDR_SPD_B));
  assign rdIsCfg  = (araddr == ADDR_W'(ADDR_CFG));
  assign rdIsStat = (araddr == ADDR_W'(ADDR_STAT));
  assign rdMapped = rdIsA || rdIsB || rdIsCfg || rdIsStat;
  assign statWord = {26'h0, lockToDiscActive, mode, speed};
  assign rdMux    = rdIsA    ? {28'h0, speedA} :
                    rdIsB    ? {28'h0, speedB} :
                    rdIsCfg  ? {28'h0, clkCfg} :
                    rdIsStat ? statWord        : 32'h0;

  // write address and data channels, taken in either order
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      awAddr  <= '0;
      wData   <= 32'h0;
      wStrb   <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        awAddr  <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wData  <= wdata;
        wStrb  <= wstrb;
      end
      if (bvalid && bready) begin
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // write response follows both channels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel answers one cycle after the address is taken
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else if (rdTake) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rdMux;
      rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // control registers; byte lane 0 carries all fields, status is read only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      speedA <= SPD_A_RST;
      speedB <= SPD_B_RST;
      clkCfg <= CFG_RST;
    end else if (wrFire && wStrb[0]) begin
      if (wrIsA) speedA <= wData[3:0];
      if (wrIsB) speedB <= wData[3:0];
      if (wrIsCfg) clkCfg <= wData[3:0];
    end
  end

  // speed selection; both top bits together keep the old factor
  assign next_speed =
    (speedA[SPD_A_DOUBLE] && speedB[SPD_B_QUAD]) ? speed :
    speedA[SPD_A_DOUBLE] ? SPD_X2 :
    speedB[SPD_B_QUAD]   ? SPD_X4 : SPD_X1;

  // standby mode selection from the first speed register
  assign stbyField = speedA[SPD_A_STBY +: 2];
  always_comb begin
    case (stbyField)
      STBY_NONE:  next_mode = ST_RUN;
      STBY_STOP:  next_mode = ST_STOP;
      STBY_PAUSE: next_mode = ST_PAUSE;
      default:    next_mode = mode;
    endcase
  end

  // mode and speed state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      speed <= SPD_X1;
      mode  <= ST_RUN;
    end else begin
      speed <= next_speed;
      mode  <= next_mode;
    end
  end

  assign standby  = (mode != ST_RUN);
  assign stopMode = (mode == ST_STOP);

  // audio pins float in either standby mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serialAudioOut          <= 3'h0;
      serialAudioOeN          <= 3'h7;
      secondLevelErrorFlag    <= 1'b0;
      secondLevelErrorFlagOeN <= 1'b1;
      biphaseMarkOutput       <= 1'b0;
      biphaseMarkOutputOeN    <= 1'b1;
    end else begin
      serialAudioOut          <= serialAudioIn;
      serialAudioOeN          <= {3{standby}};
      secondLevelErrorFlag    <= errorFlagIn;
      secondLevelErrorFlagOeN <= standby;
      biphaseMarkOutput       <= biphaseIn;
      biphaseMarkOutputOeN    <= standby;
    end
  end

  // motor pins: floating in stop and reset, driving in run and pause
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      motorDriveOutA <= 1'b0;
      motorDriveOutB <= 1'b0;
      motorDriveOeN  <= 1'b1;
    end else begin
      motorDriveOutA <= clkCfg[CFG_PDM] ? motorPdmIn[0] : motorPwmIn[0];
      motorDriveOutB <= clkCfg[CFG_PDM] ? motorPdmIn[1] : motorPwmIn[1];
      motorDriveOeN  <= stopMode;
    end
  end

  // mode status towards the core
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overspeedFactor  <= SPD_X1;
      lockToDiscActive <= 1'b0;
      coreActive       <= 1'b0;
      audioFeaturesOff <= 1'b0;
      ioShutdown       <= 1'b0;
      subcodeActive    <= 1'b0;
    end else begin
      overspeedFactor  <= next_speed;
      lockToDiscActive <= speedB[SPD_B_LTD];
      coreActive       <= 1'b1;
      audioFeaturesOff <= (next_mode != ST_RUN);
      ioShutdown       <= (next_mode == ST_STOP);
      subcodeActive    <= (next_mode != ST_STOP);
    end
  end

  // versatile pins and correction flag ignore the mode; pin inputs synchronised
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vSync1                  <= 2'h0;
      versatileToCore         <= 2'h0;
      versatilePinOut         <= 3'h0;
      correctionFlagOutput    <= 1'b0;
      correctionFlagOutputOeN <= 1'b1;
    end else begin
      vSync1                  <= versatilePinIn;
      versatileToCore         <= vSync1;
      versatilePinOut         <= versatileFromCore;
      correctionFlagOutput    <= 1'b0;
      correctionFlagOutputOeN <= correctionFlagIn;
    end
  end

  // clock outputs keep running whatever the mode
  dsc_div_if fixDiv ();
  dsc_div_if hostDiv ();

  assign fixDiv.halfCnt  = FIXED_HALF;
  assign hostDiv.halfCnt = clkCfg[CFG_HOST12] ? HOST_HI_HALF : HOST_LO_HALF;
  assign fixedClockOutput = fixDiv.clkLevel;
  assign hostClockOutput  = hostDiv.clkLevel;

  dsc_clk_div u_fix_div (
    .clk    (clk),
    .resetn (resetn),
    .link   (fixDiv.div)
  );

  dsc_clk_div u_host_div (
    .clk    (clk),
    .resetn (resetn),
    .link   (hostDiv.div)
  );

  // checks on the mode logic
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_speed_double: assert property (
    speedA[SPD_A_DOUBLE] && !speedB[SPD_B_QUAD] |=> overspeedFactor == SPD_X2)
    else $error("double speed not selected");

  a_speed_quad: assert property (
    !speedA[SPD_A_DOUBLE] && speedB[SPD_B_QUAD] |=> overspeedFactor == SPD_X4)
    else $error("quad speed not selected");

  a_speed_clash: assert property (
    speedA[SPD_A_DOUBLE] && speedB[SPD_B_QUAD] |=> $stable(overspeedFactor))
    else $error("conflicting speed bits changed the factor");

  a_ltd_follow: assert property (
    $rose(speedB[SPD_B_LTD]) |=> lockToDiscActive ##0 $past(speedB[SPD_B_LTD]))
    else $error("lock-to-disc did not follow its bit");

  a_stop_float: assert property (
    mode == ST_STOP |=> motorDriveOeN && &serialAudioOeN && (ioShutdown || mode != ST_STOP))
    else $error("stop mode left pins driven");

  a_pause_motor: assert property (
    mode == ST_PAUSE && next_mode == ST_PAUSE |=> !motorDriveOeN && subcodeActive)
    else $error("pause mode stopped the motor or subcode");

  a_audio_float: assert property (
    standby |=> secondLevelErrorFlagOeN && biphaseMarkOutputOeN &&
                audioFeaturesOff == (mode != ST_RUN))
    else $error("audio pins driven in standby");

  a_audio_drive: assert property (
    mode == ST_RUN |=> serialAudioOeN == 3'h0 && serialAudioOut == $past(serialAudioIn))
    else $error("audio pins not driven in run");

  a_bus_alive: assert property (
    standby && rdTake |=> rvalid && rdata == $past(rdMux))
    else $error("register read stalled in standby");

  a_vers_pass: assert property (
    standby |=> versatilePinOut == $past(versatileFromCore))
    else $error("versatile outputs disturbed by standby");

  a_core_alive: assert property (
    standby |-> coreActive)
    else $error("core inactive in standby");

endmodule // dsc_mode_ctrl

// ---- src/dsc_pkg.sv ----
// shared constants and types for the decoder speed and standby control
package dsc_pkg;

  // clock rates
  localparam int CLK_HZ     = 25_000_000;
  localparam int FIXED_HZ   = 16_000_000;
  localparam int HOST_LO_HZ = 4_000_000;
  localparam int HOST_HI_HZ = 12_000_000;

  // half periods in clk cycles, rounded down, never below one
  localparam int FIXED_HALF_RAW   = CLK_HZ / (2 * FIXED_HZ);
  localparam int HOST_LO_HALF_RAW = CLK_HZ / (2 * HOST_LO_HZ);
  localparam int HOST_HI_HALF_RAW = CLK_HZ / (2 * HOST_HI_HZ);
  localparam logic [7:0] FIXED_HALF =
    (FIXED_HALF_RAW < 1) ? 8'h01 : 8'(FIXED_HALF_RAW);
  localparam logic [7:0] HOST_LO_HALF =
    (HOST_LO_HALF_RAW < 1) ? 8'h01 : 8'(HOST_LO_HALF_RAW);
  localparam logic [7:0] HOST_HI_HALF =
    (HOST_HI_HALF_RAW < 1) ? 8'h01 : 8'(HOST_HI_HALF_RAW);

  // register byte offsets
  localparam logic [7:0] ADDR_SPD_A = 8'h00;
  localparam logic [7:0] ADDR_SPD_B = 8'h04;
  localparam logic [7:0] ADDR_CFG   = 8'h08;
  localparam logic [7:0] ADDR_STAT  = 8'h0c;

  // field positions
  localparam int SPD_A_DOUBLE = 3;
  localparam int SPD_A_STBY   = 0;
  localparam int SPD_B_QUAD   = 3;
  localparam int SPD_B_LTD    = 2;
  localparam int CFG_HOST12   = 0;
  localparam int CFG_PDM      = 1;

  // reset values
  localparam logic [3:0] SPD_A_RST = 4'h0;
  localparam logic [3:0] SPD_B_RST = 4'h0;
  localparam logic [3:0] CFG_RST   = 4'h0;

  // standby field codes
  localparam logic [1:0] STBY_NONE  = 2'h0;
  localparam logic [1:0] STBY_STOP  = 2'h1;
  localparam logic [1:0] STBY_PAUSE = 2'h2;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SPD_X1 = 2'h0,
    SPD_X2 = 2'h1,
    SPD_X4 = 2'h2
  } dsc_speed_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'h1,
    ST_STOP  = 3'h2,
    ST_PAUSE = 3'h4
  } dsc_mode_t;

endpackage

// ---- src/dsc_div_if.sv ----
// link between the control logic and a clock divider
interface dsc_div_if;
  logic [7:0] halfCnt;
  logic       clkLevel;
  modport ctl (output halfCnt, input clkLevel);
  modport div (input halfCnt, output clkLevel);
endinterface

// ---- src/dsc_clk_div.sv ----
// clock divider that toggles its output every programmed half period
module dsc_clk_div (
  input wire logic clk,
  input wire logic resetn,
  dsc_div_if.div   link
);

  logic [7:0] cnt;
  logic       wrap;

  // wrap when the half period has elapsed
  assign wrap = (cnt >= link.halfCnt - 8'h01);

  // count cycles and toggle the output level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt           <= 8'h00;
      link.clkLevel <= 1'b0;
    end else if (wrap) begin
      cnt           <= 8'h00;
      link.clkLevel <= ~link.clkLevel;
    end else begin
      cnt           <= cnt + 8'h01;
    end
  end

endmodule // dsc_clk_div

// ---- test/dsc_host_model.sv ----
// host controller model issuing axi4-lite register accesses
module dsc_host_model
  import dsc_pkg::*;
#(
  parameter int AW = 5
) (
  input  wire logic          clk,
  output logic [AW-1:0]      awaddr,
  output logic               awvalid,
  input  wire logic          awready,
  output logic [31:0]        wdata,
  output logic [3:0]         wstrb,
  output logic               wvalid,
  input  wire logic          wready,
  input  wire logic [1:0]    bresp,
  input  wire logic          bvalid,
  output logic               bready,
  output logic [AW-1:0]      araddr,
  output logic               arvalid,
  input  wire logic          arready,
  input  wire logic [31:0]   rdata,
  input  wire logic [1:0]    rresp,
  input  wire logic          rvalid,
  output logic               rready
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam bit VOLTAGE_MODE = 1'h1;
  localparam int DISC_PCT     = 100;

  // idle bus at time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
  end

  // one write; released lines show inverted values so stale data is never seen
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
    if ((a == ADDR_SPD_A || a == ADDR_SPD_B) && !VOLTAGE_MODE) d[3] = 1'h0;
    if (a == ADDR_SPD_B && (DISC_PCT < 25 || DISC_PCT > 100)) d[2] = 1'h0;
    @(posedge clk);
    awaddr  <= a[AW-1:0];
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'h0;
        awaddr  <= ~awaddr;
      end
      if (wvalid && wready) begin
        wvalid <= 1'h0;
        wdata  <= ~wdata;
      end
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'h0;
  endtask

  // one read
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a[AW-1:0];
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'h0;
        araddr  <= ~araddr;
      end
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
endmodule // dsc_host_model

// ---- test/test_decoder_speed_standby_control.sv ----
// self-checking bench for speed, lock-to-disc and standby control
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin errors++; \
  $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module test_decoder_speed_standby_control
  import dsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          AW  = 5;
  localparam logic [4:0]  CA  = 5'h0b;
  localparam logic [4:0]  CB  = 5'h0e;
  localparam logic [15:0] MDS = 16'h18ed;
  logic          clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready, errorFlagIn, biphaseIn, correctionFlagIn;
  logic          secondLevelErrorFlag, secondLevelErrorFlagOeN, biphaseMarkOutput;
  logic          biphaseMarkOutputOeN, motorDriveOutA, motorDriveOutB, motorDriveOeN;
  logic          correctionFlagOutput, correctionFlagOutputOeN, fixedClockOutput;
  logic          hostClockOutput, lockToDiscActive, coreActive, audioFeaturesOff;
  logic          ioShutdown, subcodeActive, pulse_density_drive, hi, a3, b3, nb, lt;
  logic [AW-1:0] awaddr, araddr;
  logic [31:0]   wdata, rdata, seed, dat;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp, rsp, motorPwmIn, motorPdmIn, versatilePinIn, versatileToCore;
  logic [1:0]    overspeedFactor, expSpd, md, code;
  logic [2:0]    serialAudioIn, versatileFromCore, serialAudioOut, serialAudioOeN;
  logic [2:0]    versatilePinOut;
  int            errors, totalChecks;

  dsc_mode_ctrl #(.ADDR_W(AW)) u_dut (
    .clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .serialAudioIn, .errorFlagIn, .biphaseIn, .motorPwmIn, .motorPdmIn, .correctionFlagIn,
    .versatilePinIn, .versatileFromCore, .serialAudioOut, .serialAudioOeN,
    .secondLevelErrorFlag, .secondLevelErrorFlagOeN, .biphaseMarkOutput, .biphaseMarkOutputOeN,
    .motorDriveOutA, .motorDriveOutB, .motorDriveOeN, .correctionFlagOutput,
    .correctionFlagOutputOeN, .versatileToCore, .versatilePinOut, .fixedClockOutput,
    .hostClockOutput, .overspeedFactor, .lockToDiscActive, .coreActive, .audioFeaturesOff,
    .ioShutdown, .subcodeActive
  );
  dsc_host_model #(.AW(AW)) u_host (
    .clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );

  // 25 MHz clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // expectation helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [1:0] speedOf(input logic [1:0] p, input logic a, input logic b);
    if (a && b) return p;
    return a ? SPD_X2 : (b ? SPD_X4 : SPD_X1);
  endfunction
  function automatic logic [31:0] statOf(input logic [1:0] s, input logic [1:0] m, input logic l);
    logic [2:0] oh;
    oh = (m == STBY_STOP) ? ST_STOP : ((m == STBY_PAUSE) ? ST_PAUSE : ST_RUN);
    return {26'h0, l, oh, s};
  endfunction

  // bus access wrappers; mode outputs are settled when a write returns
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    u_host.axiWrite(a, d, s, rsp);
    repeat (2) @(posedge clk);
    #1;
    `CHK("write resp", RESP_OKAY, rsp);
  endtask
  task automatic rdReg(input logic [7:0] a);
    u_host.axiRead(a, dat, rsp);
  endtask

  // fresh random core-side pin values
  task automatic randPins();
    @(posedge clk);
    seed = lfsr(seed);
    serialAudioIn     <= seed[2:0];
    errorFlagIn       <= seed[3];
    biphaseIn         <= seed[4];
    motorPwmIn        <= seed[6:5];
    motorPdmIn        <= seed[8:7];
    correctionFlagIn  <= seed[9];
    versatilePinIn    <= seed[11:10];
    versatileFromCore <= seed[14:12];
  endtask

  // pin states for the current standby selection
  task automatic checkPins();
    logic fl, st;
    st = (md == STBY_STOP);
    fl = st || (md == STBY_PAUSE);
    `CHK("audio oe", {3{fl}}, serialAudioOeN);
    `CHK("flag oe", {fl, fl}, {secondLevelErrorFlagOeN, biphaseMarkOutputOeN});
    if (!fl) `CHK("audio data", serialAudioIn, serialAudioOut);
    `CHK("motor oe", st, motorDriveOeN);
    if (!st) `CHK("motor", pulse_density_drive ? motorPdmIn : motorPwmIn, {motorDriveOutB, motorDriveOutA});
    `CHK("io off", st, ioShutdown);
    `CHK("features", {fl, !st}, {audioFeaturesOff, subcodeActive});
    `CHK("core", 1'h1, coreActive);
    `CHK("vpins", {versatileFromCore, versatilePinIn}, {versatilePinOut, versatileToCore});
    `CHK("correction_flag_output", {1'h0, correctionFlagIn}, {correctionFlagOutput, correctionFlagOutputOeN});
  endtask

  // output clock edges over twelve cycles
  task automatic clkCount(input logic h);
    int nf, nh;
    logic pf, ph;
    nf = 0;
    nh = 0;
    @(posedge clk);
    #1;
    for (int k = 0; k < 12; k++) begin
      pf = fixedClockOutput;
      ph = hostClockOutput;
      @(posedge clk);
      #1;
      nf += int'(pf != fixedClockOutput);
      nh += int'(ph != hostClockOutput);
    end
    `CHK("fixed clock", 12 / FIXED_HALF, nf);
    `CHK("host clock", 12 / (h ? HOST_HI_HALF : HOST_LO_HALF), nh);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    resetn = 1'h0;
    seed = 32'h3621;
    errors = 0;
    totalChecks = 0;
    pulse_density_drive = 1'h0;
    {serialAudioIn, errorFlagIn, biphaseIn, motorPwmIn, motorPdmIn} = '0;
    {correctionFlagIn, versatilePinIn, versatileFromCore} = '0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("oe in reset", 5'h1f, {serialAudioOeN, biphaseMarkOutputOeN, motorDriveOeN});
    `CHK("core in reset", 3'h0, {coreActive, overspeedFactor});
    @(posedge clk);
    resetn <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("audio oe", 3'h0, serialAudioOeN);
    expSpd = SPD_X1;
    md = STBY_NONE;
    b3 = 1'h0;
    lt = 1'h0;
    // register reset values, unmapped read, ignored writes
    for (int i = 0; i < 4; i++) begin
      rdReg(8'(i * 4));
      `CHK("reset value", (i == 3) ? statOf(SPD_X1, STBY_NONE, 1'h0) : 32'h0, dat);
    end
    rdReg(8'h10);
    `CHK("unmapped", {RESP_SLVERR, 32'h0}, {rsp, dat});
    wrReg(ADDR_STAT, 32'hffffffff, 4'hf);
    wrReg(ADDR_SPD_A, 32'h8, 4'he);
    `CHK("masked write", 2'h0, overspeedFactor);
    // corner pairs of the top bits, then random ones
    for (int i = 0; i < 14; i++) begin
      seed = lfsr(seed);
      a3 = (i < 5) ? CA[i] : seed[4];
      nb = (i < 5) ? CB[i] : seed[5];
      lt = seed[6];
      wrReg(ADDR_SPD_A, {seed[31:4], a3, 3'h0}, 4'hf);
      expSpd = speedOf(expSpd, a3, b3);
      `CHK("speed a", expSpd, overspeedFactor);
      b3 = nb;
      wrReg(ADDR_SPD_B, {seed[31:4], b3, lt, 2'h0}, 4'hf);
      expSpd = speedOf(expSpd, a3, b3);
      `CHK("speed b", expSpd, overspeedFactor);
      `CHK("lock", lt, lockToDiscActive);
      rdReg(ADDR_STAT);
      `CHK("status", statOf(expSpd, md, lt), dat);
      rdReg(ADDR_SPD_B);
      `CHK("spd b reg", {28'h0, b3, lt, 2'h0}, dat);
    end
    // every standby code, with keep-previous between them
    for (int i = 0; i < 8; i++) begin
      randPins();
      seed = lfsr(seed);
      pulse_density_drive = seed[9];
      hi = seed[10];
      wrReg(ADDR_CFG, {30'h0, pulse_density_drive, hi}, 4'hf);
      code = MDS[2 * i +: 2];
      if (code != 2'h3) md = code;
      wrReg(ADDR_SPD_A, {30'h0, code}, 4'hf);
      expSpd = speedOf(expSpd, 1'h0, b3);
      checkPins();
      rdReg(ADDR_STAT);
      `CHK("status standby", statOf(expSpd, md, lt), dat);
      clkCount(hi);
    end
    // reset in the middle of stop standby
    wrReg(ADDR_SPD_A, 32'h9, 4'hf);
    @(posedge clk);
    resetn <= 1'h0;
    #5;
    `CHK("motor oe reset", 1'h1, motorDriveOeN);
    `CHK("speed reset", 2'h0, overspeedFactor);
    @(posedge clk);
    resetn <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    md = STBY_NONE;
    pulse_density_drive = 1'h0;
    checkPins();
    tally_and_finish();
  end
endmodule // test_decoder_speed_standby_control
